// file: ocd_pkg.sv
// Shared opcodes, range table and field positions for the upper 32-bit opcode decoder
package ocd_pkg;

  typedef enum logic [6:0] {
    OP_NONE,
    OP_EXPO_LO, OP_EXPO_HI,
    OP_BMUX_SHR, OP_BMUX_SHL,
    OP_VIT1_SHL, OP_VIT1_SHR, OP_VIT2_SHL, OP_VIT2_SHR,
    OP_EXTR_Z, OP_EXTR_X, OP_DEP, OP_DEP_X,
    OP_RXSH_D, OP_RX_D, OP_RXSH_ACC, OP_RX_ACC,
    OP_BALN1, OP_BALN2, OP_BALN3,
    OP_H_SRA, OP_H_SLS, OP_H_SLL, OP_H_SRL,
    OP_V_SRA, OP_V_SLS, OP_V_SLL, OP_V_SRL,
    OP_W_SRA, OP_W_SLS, OP_W_SLL, OP_W_SRL, OP_W_ROT,
    OP_A_SRA, OP_A_SLL, OP_A_SRL, OP_A_ROT,
    OP_PNOP, OP_LOOP, OP_LOOP_P, OP_LOOP_PH,
    OP_LDI_LO, OP_LDI_X, OP_LDI_HI, OP_LDI_Z,
    OP_JUMP_L, OP_CALL,
    OP_LD_D, OP_LD_HZ, OP_LD_BZ, OP_LD_P, OP_LD_HX, OP_LD_BX,
    OP_ST_D, OP_ST_H, OP_ST_B, OP_ST_P,
    OP_LINK, OP_FRAME_A
  } ocd_op_t;

  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] care;
    ocd_op_t op;
  } ocd_rng_t;

  // Bits that must equal the range base, separating overlapping printed ranges
  localparam logic [31:0] CM_0 = 32'h00000000;
  localparam logic [31:0] CM_D = 32'h00008000;
  localparam logic [31:0] CM_H = 32'h00000180;
  localparam logic [31:0] CM_W = 32'h00000100;

  localparam int OCD_NRNG = 87;
  localparam ocd_rng_t OCD_TABLE [OCD_NRNG] = '{
    '{32'hC6078000, 32'hC6078E3F, CM_0, OP_EXPO_LO},
    '{32'hC607C000, 32'hC607CE3F, CM_0, OP_EXPO_HI},
    '{32'hC6080000, 32'hC608003F, CM_0, OP_BMUX_SHR},
    '{32'hC6084000, 32'hC608403F, CM_0, OP_BMUX_SHL},
    '{32'hC6090000, 32'hC6090E07, CM_0, OP_VIT1_SHL},
    '{32'hC6094000, 32'hC6094E07, CM_0, OP_VIT1_SHR},
    '{32'hC6098000, 32'hC6098E07, CM_0, OP_VIT2_SHL},
    '{32'hC609C000, 32'hC609CE07, CM_0, OP_VIT2_SHR},
    '{32'hC60A0000, 32'hC60A0E3F, CM_0, OP_EXTR_Z},
    '{32'hC60A4000, 32'hC60A4E3F, CM_0, OP_EXTR_X},
    '{32'hC60A8000, 32'hC60A8E3F, CM_0, OP_DEP},
    '{32'hC60AC000, 32'hC60ACE3F, CM_0, OP_DEP_X},
    '{32'hC60B0000, 32'hC60B0E38, CM_0, OP_RXSH_D},
    '{32'hC60B4000, 32'hC60B4E38, CM_0, OP_RX_D},
    '{32'hC60C0000, 32'hC60C0000, CM_0, OP_RXSH_ACC},
    '{32'hC60C4000, 32'hC60C4E00, CM_0, OP_RX_ACC},
    '{32'hC60D0000, 32'hC60D0E3F, CM_0, OP_BALN1},
    '{32'hC60D4000, 32'hC60D4E3F, CM_0, OP_BALN2},
    '{32'hC60D8000, 32'hC60D8E3F, CM_0, OP_BALN3},
    '{32'hC6800180, 32'hC6800FFF, CM_H, OP_H_SRA},
    '{32'hC6801180, 32'hC6801FFF, CM_H, OP_H_SRA},
    '{32'hC6802180, 32'hC6802FFF, CM_H, OP_H_SRA},
    '{32'hC6803180, 32'hC6803FFF, CM_H, OP_H_SRA},
    '{32'hC6804000, 32'hC6804E7F, CM_H, OP_H_SLS},
    '{32'hC6805000, 32'hC6805E7F, CM_H, OP_H_SLS},
    '{32'hC6806000, 32'hC6806E7F, CM_H, OP_H_SLS},
    '{32'hC6807000, 32'hC6807E7F, CM_H, OP_H_SLS},
    '{32'hC6808000, 32'hC6808E7F, CM_H, OP_H_SLL},
    '{32'hC6809000, 32'hC6809E7F, CM_H, OP_H_SLL},
    '{32'hC680A000, 32'hC680AE7F, CM_H, OP_H_SLL},
    '{32'hC680B000, 32'hC680BE7F, CM_H, OP_H_SLL},
    '{32'hC6808180, 32'hC6808FFF, CM_H, OP_H_SRL},
    '{32'hC6809180, 32'hC6809FFF, CM_H, OP_H_SRL},
    '{32'hC680A180, 32'hC680AFFF, CM_H, OP_H_SRL},
    '{32'hC680B180, 32'hC680BFFF, CM_H, OP_H_SRL},
    '{32'hC6810100, 32'hC6810FFF, CM_W, OP_V_SRA},
    '{32'hC6814000, 32'hC6814EFF, CM_W, OP_V_SLS},
    '{32'hC6818000, 32'hC6818E7F, CM_H, OP_V_SLL},
    '{32'hC6818180, 32'hC6818FFF, CM_H, OP_V_SRL},
    '{32'hC6820100, 32'hC6820FFF, CM_W, OP_W_SRA},
    '{32'hC6824000, 32'hC6824EFF, CM_W, OP_W_SLS},
    '{32'hC6828000, 32'hC6828EFF, CM_W, OP_W_SLL},
    '{32'hC6828100, 32'hC6828FFF, CM_W, OP_W_SRL},
    '{32'hC682C000, 32'hC682CFFF, CM_0, OP_W_ROT},
    '{32'hC6830100, 32'hC68301F8, CM_0, OP_A_SRA},
    '{32'hC6831100, 32'hC68311F8, CM_0, OP_A_SRA},
    '{32'hC6834000, 32'hC68340F8, CM_0, OP_A_SLL},
    '{32'hC6834100, 32'hC68341F8, CM_0, OP_A_SRL},
    '{32'hC6835000, 32'hC68350F8, CM_0, OP_A_SLL},
    '{32'hC6835100, 32'hC68351F8, CM_0, OP_A_SRL},
    '{32'hC6838000, 32'hC68381F8, CM_0, OP_A_ROT},
    '{32'hC6839000, 32'hC68391F8, CM_0, OP_A_ROT},
    '{32'hC8031800, 32'hC8031800, CM_0, OP_PNOP},
    '{32'hE0800000, 32'hE08F03FF, CM_0, OP_LOOP},
    '{32'hE0900000, 32'hE09F03FF, CM_0, OP_LOOP},
    '{32'hE0A00000, 32'hE0AFF3FF, CM_0, OP_LOOP_P},
    '{32'hE0B00000, 32'hE0BFF3FF, CM_0, OP_LOOP_P},
    '{32'hE0E00000, 32'hE0EFF3FF, CM_0, OP_LOOP_PH},
    '{32'hE0F00000, 32'hE0FFF3FF, CM_0, OP_LOOP_PH},
    '{32'hE1000000, 32'hE11FFFFF, CM_0, OP_LDI_LO},
    '{32'hE1200000, 32'hE13FFFFF, CM_0, OP_LDI_X},
    '{32'hE1400000, 32'hE15FFFFF, CM_0, OP_LDI_HI},
    '{32'hE1800000, 32'hE19FFFFF, CM_0, OP_LDI_Z},
    '{32'hE2000000, 32'hE2FFFFFF, CM_0, OP_JUMP_L},
    '{32'hE3000000, 32'hE3FFFFFF, CM_0, OP_CALL},
    '{32'hE4000000, 32'hE43F7FFF, CM_D, OP_LD_D},
    '{32'hE4008000, 32'hE43FFFFF, CM_D, OP_LD_D},
    '{32'hE4400000, 32'hE47F7FFF, CM_D, OP_LD_HZ},
    '{32'hE4408000, 32'hE47FFFFF, CM_D, OP_LD_HZ},
    '{32'hE4800000, 32'hE4BF7FFF, CM_D, OP_LD_BZ},
    '{32'hE4808000, 32'hE4BFFFFF, CM_D, OP_LD_BZ},
    '{32'hE5000000, 32'hE53F7FFF, CM_D, OP_LD_P},
    '{32'hE5008000, 32'hE53FFFFF, CM_D, OP_LD_P},
    '{32'hE5400000, 32'hE57F7FFF, CM_D, OP_LD_HX},
    '{32'hE5408000, 32'hE57FFFFF, CM_D, OP_LD_HX},
    '{32'hE5800000, 32'hE5BF7FFF, CM_D, OP_LD_BX},
    '{32'hE5808000, 32'hE5BFFFFF, CM_D, OP_LD_BX},
    '{32'hE6000000, 32'hE63F7FFF, CM_D, OP_ST_D},
    '{32'hE6008000, 32'hE63FFFFF, CM_D, OP_ST_D},
    '{32'hE6400000, 32'hE67F7FFF, CM_D, OP_ST_H},
    '{32'hE6408000, 32'hE67FFFFF, CM_D, OP_ST_H},
    '{32'hE6800000, 32'hE6BF7FFF, CM_D, OP_ST_B},
    '{32'hE6808000, 32'hE6BFFFFF, CM_D, OP_ST_B},
    '{32'hE7000000, 32'hE73F7FFF, CM_D, OP_ST_P},
    '{32'hE7008000, 32'hE73FFFFF, CM_D, OP_ST_P},
    '{32'hE8000000, 32'hE800FFFF, CM_0, OP_LINK},
    '{32'hE8010000, 32'hE8010000, CM_0, OP_FRAME_A}
  };

  // Field positions inside the word
  localparam int OCD_LS_MSB = 19;
  localparam int OCD_LS_LSB = 16;
  localparam int OCD_LF_MSB = 9;
  localparam int OCD_BR_MSB = 23;
  localparam int OCD_IMM_MSB = 15;
  localparam int OCD_OFF_MSB = 14;
  localparam int OCD_FR_MSB = 15;
  localparam int OCD_SC_LSB = 3;
  localparam int OCD_SC4_MSB = 6;
  localparam int OCD_SC5_MSB = 7;
  localparam int OCD_SC6_MSB = 8;
  localparam int OCD_HI_BIT = 12;
  localparam int OCD_LC_BIT = 20;
  localparam int OCD_SUB_BIT = 15;

  // Memory access sizes
  localparam logic [1:0] OCD_SZ_B = 2'h0;
  localparam logic [1:0] OCD_SZ_H = 2'h1;
  localparam logic [1:0] OCD_SZ_W = 2'h2;

endpackage

// file: ocd_fields_if.sv
// Word and opcode out to the field extractor, decoded immediates back
interface ocd_fields_if;
  import ocd_pkg::*;
  logic [31:0] word;
  ocd_op_t op;
  logic [4:0] loop_start;
  logic [10:0] loop_finish;
  logic [24:0] branch_off;
  logic [15:0] imm16;
  logic [16:0] mem_off;
  logic [17:0] frame_size;
  logic [5:0] shift_cnt;
  modport drv (output word, op,
               input loop_start, loop_finish, branch_off, imm16, mem_off, frame_size, shift_cnt);
  modport ext (input word, op,
               output loop_start, loop_finish, branch_off, imm16, mem_off, frame_size, shift_cnt);
endinterface

// file: ocd_field_extract.sv
// Immediate and offset field extraction for a decoded opcode
module ocd_field_extract
  import ocd_pkg::*;
(
  ocd_fields_if.ext fif  // Word in, fields out
);

  logic [31:0] w;
  assign w = fif.word;

  always_comb begin
    fif.loop_start = '0;
    fif.loop_finish = '0;
    fif.branch_off = '0;
    fif.imm16 = '0;
    fif.mem_off = '0;
    fif.frame_size = '0;
    fif.shift_cnt = '0;
    case (fif.op)
      OP_LOOP, OP_LOOP_P, OP_LOOP_PH: begin
        // Offsets count halfwords from the setup word
        fif.loop_start = {w[OCD_LS_MSB:OCD_LS_LSB], 1'b0};
        fif.loop_finish = {w[OCD_LF_MSB:0], 1'b0};
      end
      OP_JUMP_L, OP_CALL: begin
        fif.branch_off = {w[OCD_BR_MSB:0], 1'b0};
      end
      OP_LDI_LO, OP_LDI_X, OP_LDI_HI, OP_LDI_Z: begin
        fif.imm16 = w[OCD_IMM_MSB:0];
      end
      OP_LD_D, OP_LD_P, OP_ST_D, OP_ST_P: begin
        fif.mem_off = {w[OCD_OFF_MSB:0], 2'h0};
      end
      OP_LD_HZ, OP_LD_HX, OP_ST_H: begin
        fif.mem_off = {1'b0, w[OCD_OFF_MSB:0], 1'b0};
      end
      OP_LD_BZ, OP_LD_BX, OP_ST_B: begin
        fif.mem_off = {2'h0, w[OCD_OFF_MSB:0]};
      end
      OP_LINK: begin
        fif.frame_size = {w[OCD_FR_MSB:0], 2'h0};
      end
      OP_H_SRA, OP_H_SLS, OP_H_SLL, OP_H_SRL, OP_V_SLL, OP_V_SRL: begin
        fif.shift_cnt = {2'h0, w[OCD_SC4_MSB:OCD_SC_LSB]};
      end
      OP_V_SRA, OP_V_SLS, OP_W_SRA, OP_W_SLS, OP_W_SLL, OP_W_SRL,
      OP_A_SRA, OP_A_SLL, OP_A_SRL: begin
        fif.shift_cnt = {1'b0, w[OCD_SC5_MSB:OCD_SC_LSB]};
      end
      OP_W_ROT, OP_A_ROT: begin
        // Signed amount, kept as raw two's complement
        fif.shift_cnt = w[OCD_SC6_MSB:OCD_SC_LSB];
      end
      default: begin
        fif.shift_cnt = '0;
      end
    endcase
  end

endmodule

// file: ocd_decoder.sv
// Registered decoder for the upper 32-bit opcode ranges
module ocd_decoder
  import ocd_pkg::*;
(
  input wire logic clk_in,                // Core clock
  input wire logic rst_n_in,              // Synchronous reset, low
  input wire logic [31:0] word_in,        // Fetched instruction word
  input wire logic valid_in,              // Word is present
  output logic valid_out,                 // Decode result present
  output ocd_op_t op_out,                 // Decoded operation
  output logic illegal_out,               // Word matched nothing
  output logic src_high_out,              // Source or target is high half
  output logic acc_one_out,               // Accumulator one selected
  output logic loop_one_out,              // Loop counter one selected
  output logic sub_offset_out,            // Offset subtracted from pointer
  output logic is_load_out,               // Memory read
  output logic is_store_out,              // Memory write
  output logic [1:0] mem_size_out,        // Access size
  output logic sign_ext_out,              // Result sign extended
  output logic is_branch_out,             // Program flow change
  output logic writes_flag_out,           // Condition flag written
  output logic [4:0] loop_start_out,      // Loop start offset
  output logic [10:0] loop_finish_out,    // Loop finish offset
  output logic [24:0] branch_off_out,     // Long branch offset
  output logic [15:0] imm16_out,          // 16-bit immediate
  output logic [16:0] mem_off_out,        // Byte offset for memory
  output logic [17:0] frame_size_out,     // Frame size in bytes
  output logic [5:0] shift_cnt_out        // Shift or rotate amount
);

  ocd_fields_if fif ();

  // Lowest table index wins where ranges still overlap
  function automatic ocd_op_t f_lookup(input logic [31:0] w);
    ocd_op_t r;
    r = OP_NONE;
    for (int i = OCD_NRNG - 1; i >= 0; i--) begin
      if (w >= OCD_TABLE[i].lo && w <= OCD_TABLE[i].hi &&
          (w & OCD_TABLE[i].care) == (OCD_TABLE[i].lo & OCD_TABLE[i].care)) begin
        r = OCD_TABLE[i].op;
      end
    end
    return r;
  endfunction

  function automatic logic f_is_load(input ocd_op_t op);
    return op inside {OP_LD_D, OP_LD_HZ, OP_LD_BZ, OP_LD_P, OP_LD_HX, OP_LD_BX};
  endfunction

  function automatic logic f_is_store(input ocd_op_t op);
    return op inside {OP_ST_D, OP_ST_H, OP_ST_B, OP_ST_P};
  endfunction

  function automatic logic f_is_hshift(input ocd_op_t op);
    return op inside {OP_H_SRA, OP_H_SLS, OP_H_SLL, OP_H_SRL};
  endfunction

  function automatic logic f_is_acc(input ocd_op_t op);
    return op inside {OP_A_SRA, OP_A_SLL, OP_A_SRL, OP_A_ROT};
  endfunction

  ocd_op_t op_d;
  ocd_op_t op_q;
  logic valid_q;
  logic illegal_q;
  logic src_high_q;
  logic acc_one_q;
  logic loop_one_q;
  logic sub_offset_q;
  logic is_load_q;
  logic is_store_q;
  logic [1:0] mem_size_q;
  logic [1:0] mem_size_d;
  logic sign_ext_q;
  logic sign_ext_d;
  logic is_branch_q;
  logic writes_flag_q;
  logic [4:0] loop_start_q;
  logic [10:0] loop_finish_q;
  logic [24:0] branch_off_q;
  logic [15:0] imm16_q;
  logic [16:0] mem_off_q;
  logic [17:0] frame_size_q;
  logic [5:0] shift_cnt_q;

  assign op_d = f_lookup(word_in);
  assign fif.word = word_in;
  assign fif.op = op_d;

  ocd_field_extract u_fields (
    .fif (fif)
  );

  always_comb begin
    mem_size_d = OCD_SZ_W;
    sign_ext_d = 1'b0;
    case (op_d)
      OP_LD_HZ, OP_ST_H: begin
        mem_size_d = OCD_SZ_H;
      end
      OP_LD_HX: begin
        mem_size_d = OCD_SZ_H;
        sign_ext_d = 1'b1;
      end
      OP_LD_BZ, OP_ST_B: begin
        mem_size_d = OCD_SZ_B;
      end
      OP_LD_BX: begin
        mem_size_d = OCD_SZ_B;
        sign_ext_d = 1'b1;
      end
      OP_LDI_X, OP_EXTR_X, OP_DEP_X: begin
        sign_ext_d = 1'b1;
      end
      default: begin
        sign_ext_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      valid_q <= 1'b0;
      op_q <= OP_NONE;
      illegal_q <= 1'b0;
    end else begin
      valid_q <= valid_in;
      op_q <= op_d;
      illegal_q <= valid_in && (op_d == OP_NONE);
    end
  end

  // Selector bits taken from the word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      src_high_q <= 1'b0;
      acc_one_q <= 1'b0;
      loop_one_q <= 1'b0;
      sub_offset_q <= 1'b0;
    end else begin
      src_high_q <= (op_d == OP_EXPO_HI) || (f_is_hshift(op_d) && word_in[OCD_HI_BIT]);
      acc_one_q <= f_is_acc(op_d) && word_in[OCD_HI_BIT];
      loop_one_q <= (op_d inside {OP_LOOP, OP_LOOP_P, OP_LOOP_PH}) && word_in[OCD_LC_BIT];
      sub_offset_q <= (f_is_load(op_d) || f_is_store(op_d)) && word_in[OCD_SUB_BIT];
    end
  end

  // Pipeline class controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      is_load_q <= 1'b0;
      is_store_q <= 1'b0;
      mem_size_q <= OCD_SZ_W;
      sign_ext_q <= 1'b0;
      is_branch_q <= 1'b0;
      writes_flag_q <= 1'b0;
    end else begin
      is_load_q <= f_is_load(op_d);
      is_store_q <= f_is_store(op_d);
      mem_size_q <= mem_size_d;
      sign_ext_q <= sign_ext_d;
      is_branch_q <= op_d inside {OP_JUMP_L, OP_CALL};
      writes_flag_q <= op_d inside {OP_RXSH_D, OP_RX_D, OP_RX_ACC, OP_W_ROT, OP_A_ROT};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      loop_start_q <= '0;
      loop_finish_q <= '0;
      branch_off_q <= '0;
      imm16_q <= '0;
      mem_off_q <= '0;
      frame_size_q <= '0;
      shift_cnt_q <= '0;
    end else begin
      loop_start_q <= fif.loop_start;
      loop_finish_q <= fif.loop_finish;
      branch_off_q <= fif.branch_off;
      imm16_q <= fif.imm16;
      mem_off_q <= fif.mem_off;
      frame_size_q <= fif.frame_size;
      shift_cnt_q <= fif.shift_cnt;
    end
  end

  assign valid_out = valid_q;
  assign op_out = op_q;
  assign illegal_out = illegal_q;
  assign src_high_out = src_high_q;
  assign acc_one_out = acc_one_q;
  assign loop_one_out = loop_one_q;
  assign sub_offset_out = sub_offset_q;
  assign is_load_out = is_load_q;
  assign is_store_out = is_store_q;
  assign mem_size_out = mem_size_q;
  assign sign_ext_out = sign_ext_q;
  assign is_branch_out = is_branch_q;
  assign writes_flag_out = writes_flag_q;
  assign loop_start_out = loop_start_q;
  assign loop_finish_out = loop_finish_q;
  assign branch_off_out = branch_off_q;
  assign imm16_out = imm16_q;
  assign mem_off_out = mem_off_q;
  assign frame_size_out = frame_size_q;
  assign shift_cnt_out = shift_cnt_q;

  a_expo_high:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC607C000 |=> op_q == OP_EXPO_HI && src_high_q)
    else $error("exponent adjust high form misdecoded");

  a_bmux_bounds:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    valid_in && word_in == 32'hC6080040 |=> illegal_q && op_q == OP_NONE)
    else $error("bit multiplex range overruns");

  a_vit_order:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC6098000 ##1 word_in == 32'hC609C000 |-> op_q == OP_VIT2_SHL ##1 op_q == OP_VIT2_SHR)
    else $error("compare-select pair order wrong");

  a_extract_sign:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC60A4000 |=> op_q == OP_EXTR_X && sign_ext_q)
    else $error("sign extending extract misdecoded");

  a_deposit_map:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC60A8E3F |=> op_q == OP_DEP && !sign_ext_q)
    else $error("plain deposit misdecoded");

  a_xor_flag:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC60B4000 |=> op_q == OP_RX_D && writes_flag_q)
    else $error("reduction xor flag write missing");

  a_align_three:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC60D8000 |=> op_q == OP_BALN3)
    else $error("align by three bytes misdecoded");

  a_half_shift:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC6809188 |=> op_q == OP_H_SRL && src_high_q && shift_cnt_q == 6'h01)
    else $error("halfword logical right shift misdecoded");

  a_vec_shift:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC6818000 |=> op_q == OP_V_SLL)
    else $error("vector logical left shift misdecoded");

  a_word_shift:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC6824000 |=> op_q == OP_W_SLS)
    else $error("saturating word shift misdecoded");

  a_acc_select:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC6839000 |=> op_q == OP_A_ROT && acc_one_q)
    else $error("accumulator one rotate misdecoded");

  a_slot_noop:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hC8031800 |=> op_q == OP_PNOP && !illegal_q)
    else $error("slot no-operation misdecoded");

  a_loop_fields:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE0930005 |=> op_q == OP_LOOP && loop_one_q && loop_start_q == 5'h06 && loop_finish_q == 11'h00A)
    else $error("loop setup fields wrong");

  a_ldi_zero:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE1801234 |=> op_q == OP_LDI_Z && imm16_q == 16'h1234)
    else $error("zero extending immediate load wrong");

  a_call_offset:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE3000003 |=> op_q == OP_CALL && is_branch_q && branch_off_q == 25'h0000006)
    else $error("call offset wrong");

  a_load_sub:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE4018001 |=> op_q == OP_LD_D && sub_offset_q && mem_off_q == 17'h00004)
    else $error("subtracting word load wrong");

  a_store_add:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE6810003 |=> op_q == OP_ST_B && !sub_offset_q && mem_size_q == OCD_SZ_B)
    else $error("adding byte store wrong");

  a_frame_size:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_in == 32'hE8000010 |=> op_q == OP_LINK && frame_size_q == 18'h00040)
    else $error("frame size wrong");

  a_illegal_valid:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    valid_in && word_in == 32'hE8010001 |=> illegal_q && valid_q && op_q == OP_NONE)
    else $error("word past frame teardown not flagged illegal");

endmodule

// file: ocd_fetch_model.sv
// Fetch stage stand-in that presents one word per send request, two back-to-back per send_pair
module ocd_fetch_model (
  input wire logic clk_in,       // Core clock
  output logic [31:0] word_out,  // Word to decoder
  output logic valid_out         // Word present
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    word_out = 32'h0;
    valid_out = 1'b0;
  end
  // Bus is inverted after use so a stale word never looks like a fresh one
  task automatic send(input logic [31:0] w, input logic v);
    @(posedge clk_in);
    word_out <= w;
    valid_out <= v;
    @(posedge clk_in);
    word_out <= ~w;
    valid_out <= 1'b0;
  endtask
  // Back-to-back words, valid held high between them
  task automatic send_pair(input logic [31:0] w1, input logic [31:0] w2);
    @(posedge clk_in);
    word_out <= w1;
    valid_out <= 1'b1;
    @(posedge clk_in);
    word_out <= w2;
    @(posedge clk_in);
    word_out <= ~w2;
    valid_out <= 1'b0;
  endtask
endmodule

// file: opcode32_decode_upper_ranges_tb.sv
// Self-checking bench for the upper 32-bit opcode decoder
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module opcode32_decode_upper_ranges_tb;
  import ocd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] w; ocd_op_t o;} ocd_case_t;
  localparam ocd_case_t CASES [49] = '{
    '{32'hC6078000, OP_EXPO_LO}, '{32'hC607C000, OP_EXPO_HI}, '{32'hC608003F, OP_BMUX_SHR},
    '{32'hC6080040, OP_NONE},
    '{32'hC6084000, OP_BMUX_SHL}, '{32'hC6090000, OP_VIT1_SHL}, '{32'hC6098000, OP_VIT2_SHL},
    '{32'hC60A0000, OP_EXTR_Z}, '{32'hC60A4000, OP_EXTR_X}, '{32'hC60A8E3F, OP_DEP}, '{32'hC60AC000, OP_DEP_X},
    '{32'hC60B0000, OP_RXSH_D}, '{32'hC60B4000, OP_RX_D}, '{32'hC60C0000, OP_RXSH_ACC},
    '{32'hC60D0000, OP_BALN1}, '{32'hC60D4000, OP_BALN2}, '{32'hC60D8000, OP_BALN3},
    '{32'hC6800180, OP_H_SRA}, '{32'hC6804000, OP_H_SLS}, '{32'hC6808000, OP_H_SLL}, '{32'hC6808180, OP_H_SRL},
    '{32'hC6810100, OP_V_SRA}, '{32'hC6814000, OP_V_SLS}, '{32'hC6818000, OP_V_SLL}, '{32'hC6818180, OP_V_SRL},
    '{32'hC6820100, OP_W_SRA}, '{32'hC6824000, OP_W_SLS}, '{32'hC6828000, OP_W_SLL}, '{32'hC6828100, OP_W_SRL},
    '{32'hC682C000, OP_W_ROT}, '{32'hC6831100, OP_A_SRA}, '{32'hC6835000, OP_A_SLL}, '{32'hC6839000, OP_A_ROT},
    '{32'hC8031800, OP_PNOP}, '{32'hE0800000, OP_LOOP}, '{32'hE0B00000, OP_LOOP_P}, '{32'hE0F00000, OP_LOOP_PH},
    '{32'hE1000000, OP_LDI_LO}, '{32'hE1400000, OP_LDI_HI}, '{32'hE1801234, OP_LDI_Z}, '{32'hE2FFFFFF, OP_JUMP_L},
    '{32'hE4400000, OP_LD_HZ}, '{32'hE5808000, OP_LD_BX}, '{32'hE6400000, OP_ST_H}, '{32'hE7000000, OP_ST_P},
    '{32'hE8010000, OP_FRAME_A}, '{32'hC8031801, OP_NONE}, '{32'hE8010001, OP_NONE}, '{32'h00000000, OP_NONE}
  };
  // Label distances from the setup word, in bytes
  localparam logic [4:0] LOOP_BEGIN_OFF = 5'h1E;
  localparam logic [10:0] LOOP_END_OFF = 11'h3F4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] word;
  logic valid, vo, ill, srch, acc1, lp1, sub, ld, st, sx, br, wf;
  ocd_op_t op;
  logic [1:0] msz;
  logic [24:0] boff;
  logic [15:0] imm;
  logic [17:0] frm;
  logic [4:0] ls;
  logic [10:0] lf;
  logic [16:0] moff;
  logic [5:0] sc;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #10 clk_in = ~clk_in;
  ocd_fetch_model fetch_u (.clk_in(clk_in), .word_out(word), .valid_out(valid));
  ocd_decoder dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .word_in(word), .valid_in(valid),
    .valid_out(vo), .op_out(op), .illegal_out(ill), .src_high_out(srch), .acc_one_out(acc1),
    .loop_one_out(lp1), .sub_offset_out(sub), .is_load_out(ld), .is_store_out(st), .mem_size_out(msz),
    .sign_ext_out(sx), .is_branch_out(br), .writes_flag_out(wf), .loop_start_out(ls), .loop_finish_out(lf),
    .branch_off_out(boff), .imm16_out(imm), .mem_off_out(moff), .frame_size_out(frm), .shift_cnt_out(sc));
  task automatic give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic dec(input logic [31:0] w);
    fetch_u.send(w, 1'b1);
    #1;
  endtask
  task automatic t_reset();
    repeat (15) @(posedge clk_in);
    #1;
    `CHK({vo, op, msz}, {1'b0, OP_NONE, 2'h2})
    @(posedge clk_in) rst_n_in <= 1'b1;
  endtask
  task automatic t_table();
    foreach (CASES[i]) begin
      dec(CASES[i].w);
      `CHK({vo, op, ill}, {1'b1, CASES[i].o, CASES[i].o == OP_NONE})
    end
  endtask
  task automatic t_fields();
    dec(32'hE3000003);
    `CHK({op, br, boff}, {OP_CALL, 1'b1, 25'h6})
    dec(32'hE0930005);
    `CHK({op, lp1, ls, lf}, {OP_LOOP, 1'b1, 5'h06, 11'h00A})
    // Offsets carried as halfword counts of the label distances
    dec({12'hE08, LOOP_BEGIN_OFF[4:1], 6'h00, LOOP_END_OFF[10:1]});
    `CHK({op, lp1, ls, lf}, {OP_LOOP, 1'b0, LOOP_BEGIN_OFF, LOOP_END_OFF})
    dec(32'hE6008000);
    `CHK({op, st, ld, sub, msz}, {OP_ST_D, 3'b101, 2'h2})
    dec(32'hE6810003);
    `CHK({op, sub, msz, moff}, {OP_ST_B, 1'b0, 2'h0, 17'h00003})
    dec(32'hE5400000);
    `CHK({op, ld, sx, msz}, {OP_LD_HX, 2'b11, 2'h1})
    dec(32'hE4018001);
    `CHK({op, ld, sub, moff}, {OP_LD_D, 2'b11, 17'h00004})
    dec(32'hE4400005);
    `CHK({op, sx, msz, moff}, {OP_LD_HZ, 1'b0, 2'h1, 17'h0000A})
    dec(32'hE120ABCD);
    `CHK({op, sx, imm}, {OP_LDI_X, 1'b1, 16'hABCD})
    dec(32'hE8000010);
    `CHK({op, frm}, {OP_LINK, 18'h40})
    dec(32'hC6831100);
    `CHK({op, acc1}, {OP_A_SRA, 1'b1})
    dec(32'hC607C000);
    `CHK({op, srch}, {OP_EXPO_HI, 1'b1})
    dec(32'hC6809188);
    `CHK({op, srch, sc}, {OP_H_SRL, 1'b1, 6'h01})
    dec(32'hC682C1F8);
    `CHK({op, wf, sc}, {OP_W_ROT, 1'b1, 6'h3F})
    dec(32'hC60B4000);
    `CHK({op, wf}, {OP_RX_D, 1'b1})
    fetch_u.send(32'hC8031801, 1'b0);
    #1;
    `CHK({vo, ill}, 2'b00)
  endtask
  task automatic t_pair();
    fetch_u.send_pair(32'hC6098000, 32'hC609C000);
    #1;
    `CHK({vo, op}, {1'b1, OP_VIT2_SHR})
  endtask
  initial begin
    t_reset();
    t_table();
    t_fields();
    t_pair();
    give_verdict();
  end
endmodule
